// ===== rtl/csc_status_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - at most fifteen sync frames counted per cycle
// - rate limit flag bit 19 at offset phase
// - missing rate flag bit 18 when rate skipped
// - offset limit flag bit 17 at offset phase
// - missing offset flag bit 16 when offset skipped
// - odd cycle counts stored during idle time
// - even cycle counts stored during idle time
// - counts meaningful only for assigned channels
// - idle boundary/syntax flags updated at idle end
// - window flags update at window end, not startup
// - test symbol seen flags bits 7 and 6
// - window collision flags bits 5 and 2
// - window boundary flags bits 4 and 1
// - window syntax flags bits 3 and 0
// - aggregated status gathers slot, window, idle events
// - aggregated flags sticky, write one clears, reset clears
// - valid frame flags bits 8 and 0
// - boundary flags bits 12 and 4
// - extra traffic flag bit 3 on mixed slot
// - content error flag bit 2
// - syntax error flag bit 1
// - new error flag pulses channel error interrupt
module csc_status_top
(
  input wire logic mclk,
  input wire logic reset_n,
  // host register access
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // configuration
  input wire logic channel_a_assigned,
  input wire logic channel_b_assigned,
  input wire logic [csc_pkg::MAX_RATE_W-1:0] max_rate_correction,
  input wire logic [csc_pkg::MAX_OFFSET_W-1:0] max_offset_correction,
  // clock sync results
  input wire logic offset_phase_start,
  input wire logic [csc_pkg::RATE_W-1:0] rate_correction,
  input wire logic [csc_pkg::OFFSET_W-1:0] offset_correction,
  input wire logic rate_skipped,
  input wire logic offset_skipped,
  // cycle timing
  input wire logic cycle_start,
  input wire logic cycle_odd,
  input wire logic network_idle_time,
  input wire logic startup_active,
  input wire logic sync_valid_a,
  input wire logic sync_valid_b,
  // slot results, sampled on slot_end
  input wire logic slot_end_a,
  input wire logic slot_valid_a,
  input wire logic slot_syntax_a,
  input wire logic slot_content_a,
  input wire logic slot_boundary_a,
  input wire logic slot_end_b,
  input wire logic slot_valid_b,
  input wire logic slot_syntax_b,
  input wire logic slot_content_b,
  input wire logic slot_boundary_b,
  // symbol window results, sampled on window_end
  input wire logic window_end_a,
  input wire logic window_symbol_a,
  input wire logic window_collision_a,
  input wire logic window_boundary_a,
  input wire logic window_syntax_a,
  input wire logic window_end_b,
  input wire logic window_symbol_b,
  input wire logic window_collision_b,
  input wire logic window_boundary_b,
  input wire logic window_syntax_b,
  // idle time results, sampled on idle_end
  input wire logic idle_end_a,
  input wire logic idle_boundary_in_a,
  input wire logic idle_syntax_in_a,
  input wire logic idle_end_b,
  input wire logic idle_boundary_in_b,
  input wire logic idle_syntax_in_b,
  // error interrupt pulses
  output logic error_detected_a_irq,
  output logic error_detected_b_irq
);

  // =====================================================================
  // state
  typedef struct packed
  {
    logic rate_limit_flag;
    logic missing_rate_signal;
    logic offset_limit_flag;
    logic missing_offset_signal;
    logic [3:0] sync_count_b_odd;
    logic [3:0] sync_count_b_even;
    logic [3:0] sync_count_a_odd;
    logic [3:0] sync_count_a_even;
    logic idle_boundary_b;
    logic idle_syntax_b;
    logic idle_boundary_a;
    logic idle_syntax_a;
    logic test_symbol_seen_b;
    logic test_symbol_seen_a;
    logic window_collision_b;
    logic window_boundary_b;
    logic window_syntax_b;
    logic window_collision_a;
    logic window_boundary_a;
    logic window_syntax_a;
    logic idle_seen;
    logic [31:0] rdata;
  } csc_top_state_type;

  csc_top_state_type state_ff;
  csc_top_state_type nxt_state;

  logic [3:0] count_a;
  logic [3:0] count_b;
  logic [csc_pkg::FLAGS_W-1:0] events_a;
  logic [csc_pkg::FLAGS_W-1:0] events_b;
  logic [csc_pkg::FLAGS_W-1:0] flags_a;
  logic [csc_pkg::FLAGS_W-1:0] flags_b;
  logic agg_clear_wr;
  logic [csc_pkg::RATE_W-1:0] rate_abs;
  logic [csc_pkg::OFFSET_W-1:0] offset_abs;
  logic rate_over;
  logic offset_over;
  logic idle_first;
  logic [31:0] sync_word;
  logic [31:0] window_word;
  logic [31:0] agg_word;

  // =====================================================================
  // sync frame counters
  csc_sync_count u_count_a
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .cycle_start(cycle_start),
    .frame_valid(sync_valid_a),
    .chan_assigned(channel_a_assigned),
    .count_ff(count_a)
  );

  csc_sync_count u_count_b
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .cycle_start(cycle_start),
    .frame_valid(sync_valid_b),
    .chan_assigned(channel_b_assigned),
    .count_ff(count_b)
  );

  // =====================================================================
  // correction limit compare, two's complement magnitude
  always_comb
  begin
    rate_abs = rate_correction[csc_pkg::RATE_W-1] ? (~rate_correction + 12'h001) :
      rate_correction;
    offset_abs = offset_correction[csc_pkg::OFFSET_W-1] ?
      (~offset_correction + 19'h0_0001) : offset_correction;
    rate_over = rate_abs > {1'b0, max_rate_correction};
    offset_over = offset_abs > {5'h00, max_offset_correction};
  end

  // =====================================================================
  // aggregated events per channel
  always_comb
  begin
    events_a = '0;
    events_a[csc_pkg::FLAG_VALID_FRAME] = slot_end_a & slot_valid_a;
    events_a[csc_pkg::FLAG_CONTENT] = slot_end_a & slot_content_a;
    events_a[csc_pkg::FLAG_EXTRA] = slot_end_a & slot_valid_a &
      (slot_syntax_a | slot_content_a | slot_boundary_a);
    events_a[csc_pkg::FLAG_SYNTAX] = (slot_end_a & slot_syntax_a) |
      (window_end_a & window_syntax_a) | (idle_end_a & idle_syntax_in_a);
    events_a[csc_pkg::FLAG_BOUNDARY] = (slot_end_a & slot_boundary_a) |
      (window_end_a & window_boundary_a) | (idle_end_a & idle_boundary_in_a);
    events_b = '0;
    events_b[csc_pkg::FLAG_VALID_FRAME] = slot_end_b & slot_valid_b;
    events_b[csc_pkg::FLAG_CONTENT] = slot_end_b & slot_content_b;
    events_b[csc_pkg::FLAG_EXTRA] = slot_end_b & slot_valid_b &
      (slot_syntax_b | slot_content_b | slot_boundary_b);
    events_b[csc_pkg::FLAG_SYNTAX] = (slot_end_b & slot_syntax_b) |
      (window_end_b & window_syntax_b) | (idle_end_b & idle_syntax_in_b);
    events_b[csc_pkg::FLAG_BOUNDARY] = (slot_end_b & slot_boundary_b) |
      (window_end_b & window_boundary_b) | (idle_end_b & idle_boundary_in_b);
  end

  assign agg_clear_wr = reg_wr && reg_addr == csc_pkg::AGG_STATUS_OFFSET;

  csc_chan_flags u_flags_a
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .set_events(events_a),
    .clear_wr(agg_clear_wr),
    .clear_mask(reg_wdata[csc_pkg::AGG_A_LSB +: csc_pkg::FLAGS_W]),
    .flags_ff(flags_a),
    .error_irq_ff(error_detected_a_irq)
  );

  csc_chan_flags u_flags_b
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .set_events(events_b),
    .clear_wr(agg_clear_wr),
    .clear_mask(reg_wdata[csc_pkg::AGG_B_LSB +: csc_pkg::FLAGS_W]),
    .flags_ff(flags_b),
    .error_irq_ff(error_detected_b_irq)
  );

  // =====================================================================
  // register images
  always_comb
  begin
    sync_word = csc_pkg::SYNC_STATUS_RESET;
    sync_word[csc_pkg::RATE_LIMIT_BIT] = state_ff.rate_limit_flag;
    sync_word[csc_pkg::MISSING_RATE_BIT] = state_ff.missing_rate_signal;
    sync_word[csc_pkg::OFFSET_LIMIT_BIT] = state_ff.offset_limit_flag;
    sync_word[csc_pkg::MISSING_OFFSET_BIT] = state_ff.missing_offset_signal;
    sync_word[csc_pkg::COUNT_B_ODD_LSB +: 4] = state_ff.sync_count_b_odd;
    sync_word[csc_pkg::COUNT_B_EVEN_LSB +: 4] = state_ff.sync_count_b_even;
    sync_word[csc_pkg::COUNT_A_ODD_LSB +: 4] = state_ff.sync_count_a_odd;
    sync_word[csc_pkg::COUNT_A_EVEN_LSB +: 4] = state_ff.sync_count_a_even;
    window_word = csc_pkg::WINDOW_STATUS_RESET;
    window_word[csc_pkg::IDLE_BOUNDARY_B_BIT] = state_ff.idle_boundary_b;
    window_word[csc_pkg::IDLE_SYNTAX_B_BIT] = state_ff.idle_syntax_b;
    window_word[csc_pkg::IDLE_BOUNDARY_A_BIT] = state_ff.idle_boundary_a;
    window_word[csc_pkg::IDLE_SYNTAX_A_BIT] = state_ff.idle_syntax_a;
    window_word[csc_pkg::TEST_SYMBOL_B_BIT] = state_ff.test_symbol_seen_b;
    window_word[csc_pkg::TEST_SYMBOL_A_BIT] = state_ff.test_symbol_seen_a;
    window_word[csc_pkg::WIN_COLLISION_B_BIT] = state_ff.window_collision_b;
    window_word[csc_pkg::WIN_BOUNDARY_B_BIT] = state_ff.window_boundary_b;
    window_word[csc_pkg::WIN_SYNTAX_B_BIT] = state_ff.window_syntax_b;
    window_word[csc_pkg::WIN_COLLISION_A_BIT] = state_ff.window_collision_a;
    window_word[csc_pkg::WIN_BOUNDARY_A_BIT] = state_ff.window_boundary_a;
    window_word[csc_pkg::WIN_SYNTAX_A_BIT] = state_ff.window_syntax_a;
    agg_word = csc_pkg::AGG_STATUS_RESET;
    agg_word[csc_pkg::AGG_A_LSB +: csc_pkg::FLAGS_W] = flags_a;
    agg_word[csc_pkg::AGG_B_LSB +: csc_pkg::FLAGS_W] = flags_b;
  end

  // store on the first cycle of each idle time
  assign idle_first = network_idle_time && !state_ff.idle_seen;

  // =====================================================================
  // next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.idle_seen = network_idle_time;
    if (offset_phase_start)
    begin
      nxt_state.rate_limit_flag = rate_over;
      nxt_state.missing_rate_signal = rate_skipped;
      nxt_state.offset_limit_flag = offset_over;
      nxt_state.missing_offset_signal = offset_skipped;
    end
    if (idle_first && cycle_odd)
    begin
      nxt_state.sync_count_b_odd = count_b;
      nxt_state.sync_count_a_odd = count_a;
    end
    if (idle_first && !cycle_odd)
    begin
      nxt_state.sync_count_b_even = count_b;
      nxt_state.sync_count_a_even = count_a;
    end
    if (idle_end_a)
    begin
      nxt_state.idle_boundary_a = idle_boundary_in_a;
      nxt_state.idle_syntax_a = idle_syntax_in_a;
    end
    if (idle_end_b)
    begin
      nxt_state.idle_boundary_b = idle_boundary_in_b;
      nxt_state.idle_syntax_b = idle_syntax_in_b;
    end
    if (window_end_a && !startup_active)
    begin
      nxt_state.test_symbol_seen_a = window_symbol_a;
      nxt_state.window_collision_a = window_collision_a;
      nxt_state.window_boundary_a = window_boundary_a;
      nxt_state.window_syntax_a = window_syntax_a;
    end
    if (window_end_b && !startup_active)
    begin
      nxt_state.test_symbol_seen_b = window_symbol_b;
      nxt_state.window_collision_b = window_collision_b;
      nxt_state.window_boundary_b = window_boundary_b;
      nxt_state.window_syntax_b = window_syntax_b;
    end
    nxt_state.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        csc_pkg::SYNC_STATUS_OFFSET: nxt_state.rdata = sync_word;
        csc_pkg::WINDOW_STATUS_OFFSET: nxt_state.rdata = window_word;
        csc_pkg::AGG_STATUS_OFFSET: nxt_state.rdata = agg_word;
        default: nxt_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_offset_phase;
    offset_phase_start;
  endsequence

  sequence s_odd_idle_entry;
    !network_idle_time ##1 (network_idle_time && cycle_odd);
  endsequence

  sequence s_even_idle_entry;
    !network_idle_time ##1 (network_idle_time && !cycle_odd);
  endsequence

  chk_rate_limit_flag: assert property (
    s_offset_phase |=> state_ff.rate_limit_flag == $past(rate_over))
  else $error("rate limit flag not taken at offset phase");

  chk_missing_rate: assert property (
    s_offset_phase |=> state_ff.missing_rate_signal == $past(rate_skipped))
  else $error("missing rate flag not taken at offset phase");

  chk_offset_limit_flag: assert property (
    s_offset_phase |=> state_ff.offset_limit_flag == $past(offset_over))
  else $error("offset limit flag not taken at offset phase");

  chk_missing_offset: assert property (
    !offset_phase_start |=> state_ff.missing_offset_signal == $past(state_ff.missing_offset_signal))
  else $error("missing offset flag moved outside offset phase");

  chk_odd_count_store: assert property (
    s_odd_idle_entry |=> state_ff.sync_count_a_odd == $past(count_a)
      && state_ff.sync_count_b_odd == $past(count_b))
  else $error("odd cycle sync counts not stored in idle time");

  chk_even_count_store: assert property (
    s_even_idle_entry |=> state_ff.sync_count_a_even == $past(count_a)
      && state_ff.sync_count_b_even == $past(count_b))
  else $error("even cycle sync counts not stored in idle time");

  chk_unassigned_zero: assert property (
    !channel_a_assigned |=> count_a == 4'h0)
  else $error("unassigned channel kept a sync count");

  chk_unassigned_b: assert property (
    !channel_b_assigned |=> count_b == 4'h0)
  else $error("unassigned channel b kept a sync count");

  chk_idle_flags: assert property (
    idle_end_b |=> state_ff.idle_syntax_b == $past(idle_syntax_in_b)
      && state_ff.idle_boundary_b == $past(idle_boundary_in_b))
  else $error("idle time flags not updated at idle end");

  chk_startup_hold: assert property (
    (startup_active && window_end_a) |=> $stable(state_ff.test_symbol_seen_a)
      && $stable(state_ff.window_syntax_a))
  else $error("window flags changed during startup");

  chk_window_mts: assert property (
    (window_end_b && !startup_active) |=> state_ff.test_symbol_seen_b == $past(window_symbol_b))
  else $error("test symbol flag not updated at window end");

  chk_extra_traffic: assert property (
    (slot_end_a && slot_valid_a && slot_content_a) |=> flags_a[csc_pkg::FLAG_EXTRA])
  else $error("extra traffic flag missed for mixed slot");

  chk_read_agg: assert property (
    (reg_rd && reg_addr == csc_pkg::AGG_STATUS_OFFSET) |=> reg_rdata[12:8] == $past(flags_b))
  else $error("channel b aggregated flags at wrong position");

endmodule
`default_nettype wire

// ===== pkg/csc_pkg.sv
// constants shared by the cluster sync / channel status block
package csc_pkg;

  // =====================================================================
  // register offsets
  localparam logic [11:0] SYNC_STATUS_OFFSET = 12'h120;
  localparam logic [11:0] WINDOW_STATUS_OFFSET = 12'h124;
  localparam logic [11:0] AGG_STATUS_OFFSET = 12'h128;

  // =====================================================================
  // reset values
  localparam logic [31:0] SYNC_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] WINDOW_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] AGG_STATUS_RESET = 32'h0000_0000;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  // =====================================================================
  // widths and limits
  localparam int COUNT_W = 4;
  localparam logic [3:0] SYNC_COUNT_MAX = 4'hf;
  localparam int RATE_W = 12;
  localparam int MAX_RATE_W = 11;
  localparam int OFFSET_W = 19;
  localparam int MAX_OFFSET_W = 14;
  localparam int FLAGS_W = 5;

  // =====================================================================
  // sync frame status field positions
  localparam int RATE_LIMIT_BIT = 19;
  localparam int MISSING_RATE_BIT = 18;
  localparam int OFFSET_LIMIT_BIT = 17;
  localparam int MISSING_OFFSET_BIT = 16;
  localparam int COUNT_B_ODD_LSB = 12;
  localparam int COUNT_B_EVEN_LSB = 8;
  localparam int COUNT_A_ODD_LSB = 4;
  localparam int COUNT_A_EVEN_LSB = 0;

  // =====================================================================
  // symbol window / idle status field positions
  localparam int IDLE_BOUNDARY_B_BIT = 11;
  localparam int IDLE_SYNTAX_B_BIT = 10;
  localparam int IDLE_BOUNDARY_A_BIT = 9;
  localparam int IDLE_SYNTAX_A_BIT = 8;
  localparam int TEST_SYMBOL_B_BIT = 7;
  localparam int TEST_SYMBOL_A_BIT = 6;
  localparam int WIN_COLLISION_B_BIT = 5;
  localparam int WIN_BOUNDARY_B_BIT = 4;
  localparam int WIN_SYNTAX_B_BIT = 3;
  localparam int WIN_COLLISION_A_BIT = 2;
  localparam int WIN_BOUNDARY_A_BIT = 1;
  localparam int WIN_SYNTAX_A_BIT = 0;

  // =====================================================================
  // aggregated status: per-channel flag order, channel b sits 8 higher
  localparam int FLAG_VALID_FRAME = 0;
  localparam int FLAG_SYNTAX = 1;
  localparam int FLAG_CONTENT = 2;
  localparam int FLAG_EXTRA = 3;
  localparam int FLAG_BOUNDARY = 4;
  localparam int AGG_A_LSB = 0;
  localparam int AGG_B_LSB = 8;

endpackage

// ===== rtl/csc_sync_count.sv
`timescale 1ns/1ps
`default_nettype none
// per-channel valid sync frame counter for one communication cycle
module csc_sync_count
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cycle_start,
  input wire logic frame_valid,
  input wire logic chan_assigned,
  output logic [csc_pkg::COUNT_W-1:0] count_ff
);

  typedef struct packed
  {
    logic [csc_pkg::COUNT_W-1:0] count;
  } csc_cnt_state_type;

  csc_cnt_state_type state_ff;
  csc_cnt_state_type nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    if (cycle_start || !chan_assigned)
    begin
      nxt_state.count = csc_pkg::COUNT_RESET;
    end
    else if (frame_valid && state_ff.count != csc_pkg::SYNC_COUNT_MAX)
    begin
      nxt_state.count = state_ff.count + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign count_ff = state_ff.count;

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_count_saturates: assert property (
    (state_ff.count == 4'hf && !cycle_start && chan_assigned) |=> state_ff.count == 4'hf)
  else $error("sync count left its saturation value");

  chk_count_steps: assert property (
    (frame_valid && !cycle_start && chan_assigned && state_ff.count != 4'hf)
    |=> state_ff.count == $past(state_ff.count) + 4'h1)
  else $error("sync count did not advance on a valid frame");

endmodule
`default_nettype wire

// ===== rtl/csc_chan_flags.sv
`timescale 1ns/1ps
`default_nettype none
// sticky aggregated flags of one channel with write-one-to-clear and error pulse
module csc_chan_flags
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [csc_pkg::FLAGS_W-1:0] set_events,
  input wire logic clear_wr,
  input wire logic [csc_pkg::FLAGS_W-1:0] clear_mask,
  output logic [csc_pkg::FLAGS_W-1:0] flags_ff,
  output logic error_irq_ff
);

  typedef struct packed
  {
    logic [csc_pkg::FLAGS_W-1:0] flags;
    logic irq;
  } csc_flag_state_type;

  csc_flag_state_type state_ff;
  csc_flag_state_type nxt_state;
  logic [csc_pkg::FLAGS_W-1:0] clr_bits;
  logic [csc_pkg::FLAGS_W-1:0] rising;

  always_comb
  begin
    clr_bits = clear_wr ? clear_mask : '0;
    nxt_state.flags = (state_ff.flags & ~clr_bits) | set_events;
    rising = nxt_state.flags & ~state_ff.flags;
    // valid frame alone is not an error
    nxt_state.irq = |(rising & ~(5'h01 << csc_pkg::FLAG_VALID_FRAME));
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign flags_ff = state_ff.flags;
  assign error_irq_ff = state_ff.irq;

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_flags_sticky: assert property (
    !clear_wr |=> (state_ff.flags & $past(state_ff.flags)) == $past(state_ff.flags))
  else $error("aggregated flag dropped without a clear");

  chk_set_wins: assert property (
    (set_events != 5'h00) |=> (state_ff.flags & $past(set_events)) == $past(set_events))
  else $error("event lost against a clear");

  chk_irq_edge: assert property (
    (set_events[csc_pkg::FLAG_SYNTAX] && !state_ff.flags[csc_pkg::FLAG_SYNTAX])
    |=> state_ff.irq)
  else $error("no error pulse on a new syntax flag");

endmodule
`default_nettype wire

// ===== sim/csc_node_model.sv
`timescale 1ns/1ps
`default_nettype none
// far nodes: one sync frame every second cycle until the loaded count is spent
module csc_node_model
(
  input wire logic mclk,
  input wire logic load,
  input wire logic [4:0] frames,
  output logic sync_pulse
);
  logic [4:0] left_ff = 5'h00;
  logic phase_ff = 1'b0;
  always @(posedge mclk)
  begin
    phase_ff <= ~phase_ff;
    if (load)
      left_ff <= frames;
    else if (phase_ff && left_ff != 5'h00)
      left_ff <= left_ff - 5'h01;
  end
  assign sync_pulse = phase_ff && !load && left_ff != 5'h00;
endmodule
`default_nettype wire

// ===== sim/cluster_sync_channel_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module cluster_sync_channel_status_test;
  logic mclk, reset_n, reg_rd, reg_wr, channel_a_assigned, channel_b_assigned, load;
  logic [11:0] reg_addr, rate_correction;
  logic [31:0] reg_wdata, reg_rdata;
  logic [10:0] max_rate_correction;
  logic [13:0] max_offset_correction;
  logic [18:0] offset_correction;
  logic [4:0] fr_a, fr_b;
  logic offset_phase_start, rate_skipped, offset_skipped, cycle_start, cycle_odd, sync_valid_a;
  logic network_idle_time, startup_active, sync_valid_b, error_detected_a_irq;
  logic slot_end_a, slot_valid_a, slot_syntax_a, slot_content_a, slot_boundary_a, idle_end_a;
  logic window_end_a, window_symbol_a, window_collision_a, window_boundary_a, window_syntax_a;
  logic window_end_b, window_symbol_b, window_collision_b, window_boundary_b, window_syntax_b;
  logic idle_boundary_in_a, idle_syntax_in_a, idle_end_b, idle_boundary_in_b, idle_syntax_in_b;
  logic error_detected_b_irq;
  int err_total, checked;
  csc_status_top u_csc_status_top (.*, .slot_end_b(1'b0), .slot_valid_b(1'b0),
    .slot_syntax_b(1'b0), .slot_content_b(1'b0), .slot_boundary_b(1'b0));
  csc_node_model u_node_a (.mclk, .load, .frames(fr_a), .sync_pulse(sync_valid_a));
  csc_node_model u_node_b (.mclk, .load, .frames(fr_b), .sync_pulse(sync_valid_b));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    repeat (2000) @(posedge mclk);
    err_total++;
    give_verdict();
  end
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk);
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {~wr, wr, a, d};
    @(negedge mclk);
    {reg_rd, reg_wr} = 2'h0;
    if (!wr)
      chk_word(d, reg_rdata);
  endtask
  task automatic sync_cycle(input logic odd, input logic [4:0] a, input logic [4:0] b);
    {cycle_start, load, cycle_odd, fr_a, fr_b} = {2'h3, odd, a, b};
    @(negedge mclk);
    {cycle_start, load} = 2'h0;
    repeat (40) @(negedge mclk);
    network_idle_time = 1'b1;
    repeat (2) @(negedge mclk);
    network_idle_time = 1'b0;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    {reset_n, reg_rd, reg_wr, reg_addr, reg_wdata, load, fr_a, fr_b, rate_correction} = '0;
    {offset_correction, offset_phase_start, rate_skipped, offset_skipped, cycle_start} = '0;
    {cycle_odd, network_idle_time, startup_active, slot_end_a, slot_valid_a, slot_syntax_a} = '0;
    {slot_content_a, slot_boundary_a, idle_end_a, idle_boundary_in_a, idle_syntax_in_a} = '0;
    {window_end_a, window_symbol_a, window_collision_a, window_boundary_a, window_syntax_a} = '0;
    {window_end_b, window_symbol_b, window_collision_b, window_boundary_b, window_syntax_b} = '0;
    {idle_end_b, idle_boundary_in_b, idle_syntax_in_b, channel_a_assigned} = 4'h1;
    channel_b_assigned = 1'b1;
    max_rate_correction = 11'h064;
    max_offset_correction = 14'h0032;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    bus(1'b0, 12'h128, 32'h0000_0000);
    bus(1'b0, 12'h12c, 32'h0000_0000);
    sync_cycle(1'b1, 5'h11, 5'h03);
    bus(1'b0, 12'h120, 32'h0000_30f0);
    channel_b_assigned = 1'b0;
    sync_cycle(1'b0, 5'h02, 5'h05);
    channel_b_assigned = 1'b1;
    bus(1'b0, 12'h120, 32'h0000_30f2);
    {rate_correction, rate_skipped, offset_correction, offset_skipped} = 33'h1_f370_0064;
    offset_phase_start = 1'b1;
    @(negedge mclk);
    offset_phase_start = 1'b0;
    bus(1'b0, 12'h120, 32'h000c_30f2);
    {rate_correction, rate_skipped, offset_correction, offset_skipped} = 33'h0_0c8f_ff9b;
    offset_phase_start = 1'b1;
    @(negedge mclk);
    offset_phase_start = 1'b0;
    bus(1'b0, 12'h120, 32'h0003_30f2);
    $display("test clock sync done");
    {startup_active, window_symbol_b, window_end_b, window_end_a} = 4'hf;
    @(negedge mclk);
    {startup_active, window_end_b, window_end_a, idle_end_b, idle_end_a, idle_syntax_in_a} = 6'h0f;
    {window_symbol_a, window_collision_a, window_boundary_a, window_syntax_a} = 4'hf;
    {idle_boundary_in_b, idle_syntax_in_b} = 2'h3;
    @(negedge mclk);
    {window_end_a, idle_end_b, idle_end_a} = 3'h0;
    chk_word(32'h0000_0001, {31'h0, error_detected_b_irq});
    bus(1'b0, 12'h124, 32'h0000_0d47);
    bus(1'b0, 12'h128, 32'h0000_1212);
    $display("test window done");
    bus(1'b1, 12'h124, 32'hffff_ffff);
    bus(1'b1, 12'h128, 32'h0000_0210);
    bus(1'b0, 12'h128, 32'h0000_1002);
    bus(1'b0, 12'h124, 32'h0000_0d47);
    window_end_b = 1'b1;
    @(negedge mclk);
    window_end_b = 1'b0;
    bus(1'b0, 12'h124, 32'h0000_0dc7);
    bus(1'b1, 12'h128, 32'hffff_ffff);
    {slot_end_a, slot_valid_a, slot_content_a} = 3'h7;
    @(negedge mclk);
    slot_end_a = 1'b0;
    chk_word(32'h0000_0001, {31'h0, error_detected_a_irq});
    @(negedge mclk);
    chk_word(32'h0000_0000, {31'h0, error_detected_a_irq});
    bus(1'b0, 12'h128, 32'h0000_000d);
    $display("test aggregated done");
    give_verdict();
  end
endmodule
`default_nettype wire
